// ### shared/cmt_pkg.sv
// constants, offsets and types for the connection-management condition block
package cmt_pkg;

   // ===========================================================
   // clock and timing
   localparam int CLK_PERIOD_NS = 4;
   localparam real SCRUB_TICK_US = 40.96;
   localparam int SCRUB_TICK_CYCLES =
      int'(SCRUB_TICK_US * 1000.0 / real'(CLK_PERIOD_NS));
   localparam int SYMBOL_NS = 8;
   localparam int INVALID_SYMBOLS = 2;
   localparam int INVALID_CYCLES =
      (INVALID_SYMBOLS * SYMBOL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ===========================================================
   // register offsets on the control bus
   localparam logic [7:0] OFS_HISTORY = 8'h20;
   localparam logic [7:0] OFS_MASK = 8'h21;
   localparam logic [7:0] OFS_RSVD_LO = 8'h22;
   localparam logic [7:0] OFS_RSVD_HI = 8'h23;
   localparam logic [7:0] OFS_THRESHOLD = 8'h24;
   localparam logic [7:0] OFS_SNAPSHOT = 8'h25;

   // ===========================================================
   // field positions and reset values
   localparam int TRIG_BIT = 7;
   localparam int SCRUB_BIT = 6;
   localparam logic [7:0] IMPL_BITS = 8'hC0;
   localparam logic [7:0] HISTORY_RESET = 8'h00;
   localparam logic [7:0] MASK_RESET = 8'h00;
   localparam logic [7:0] THRESHOLD_RESET = 8'h00;

   // ===========================================================
   // scrub sequencer states, gray along idle -> invalid -> scrub
   typedef enum logic [1:0] {
      SCRUB_IDLE = 2'b00,
      SCRUB_INVALID = 2'b01,
      SCRUB_PAIRS = 2'b11
   } scrub_state_e;

endpackage

// ### shared/scrub_if.sv
// carrier between the condition logic and the scrub timer
`timescale 1ns/1ps
interface scrub_if;
   logic start;
   logic [7:0] threshold;
   logic expired;
   logic active;
   logic send_invalid;
   logic [7:0] snapshot;

   modport ctl (
      output start,
      output threshold,
      input expired,
      input active,
      input send_invalid,
      input snapshot
   );
   modport tmr (
      input start,
      input threshold,
      output expired,
      output active,
      output send_invalid,
      output snapshot
   );
endinterface

// ### logic/scrub_timer.sv
// scrub timer: prescaler, tick down-counter and invalid-symbol lead-in
`timescale 1ns/1ps
module scrub_timer #(
   parameter int TICK_CYCLES = cmt_pkg::SCRUB_TICK_CYCLES
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // control side
   scrub_if.tmr sif
);

   localparam int PW = $clog2(TICK_CYCLES + 1);
   localparam logic [PW-1:0] PRE_LAST = PW'(TICK_CYCLES - 1);
   localparam logic [2:0] INV_LAST = 3'(cmt_pkg::INVALID_CYCLES - 1);

   typedef struct packed {
      cmt_pkg::scrub_state_e st;
      logic [PW-1:0] pre;
      logic [7:0] count;
      logic [2:0] inv;
      logic expired;
   } tmr_s;

   tmr_s r;
   tmr_s next_r;

   // ===========================================================
   // next state
   always_comb begin
      logic tick;
      tick = 1'b0;
      next_r = r;
      next_r.expired = 1'b0;
      tick = (r.pre == PRE_LAST);
      if (r.st != cmt_pkg::SCRUB_IDLE) begin
         next_r.pre = tick ? '0 : r.pre + PW'(1);
      end
      case (r.st)
         cmt_pkg::SCRUB_IDLE: begin
            if (sif.start) begin
               // threshold captured here, later writes do not reach it
               next_r.count = sif.threshold;
               next_r.pre = '0;
               next_r.inv = '0;
               next_r.st = cmt_pkg::SCRUB_INVALID;
            end
         end
         cmt_pkg::SCRUB_INVALID: begin
            next_r.inv = r.inv + 3'h1;
            if (r.inv == INV_LAST) begin
               next_r.st = cmt_pkg::SCRUB_PAIRS;
            end
         end
         cmt_pkg::SCRUB_PAIRS: begin
         end
         default: begin
            next_r.st = cmt_pkg::SCRUB_IDLE;
         end
      endcase
      // a zero threshold expires at the first tick
      if (r.st != cmt_pkg::SCRUB_IDLE && tick) begin
         if (r.count <= 8'h01) begin
            next_r.count = 8'h00;
            next_r.expired = 1'b1;
            next_r.st = cmt_pkg::SCRUB_IDLE;
         end else begin
            next_r.count = r.count - 8'h01;
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign sif.expired = r.expired;
   assign sif.active = (r.st != cmt_pkg::SCRUB_IDLE);
   assign sif.send_invalid = (r.st == cmt_pkg::SCRUB_INVALID);
   assign sif.snapshot = r.count;

endmodule

// ### logic/cmt_condition_scrub_timer.sv
// connection-management condition registers with trigger-started scrub
//
// Notes on behaviour
// - condition flags stay set until software clears
// - flag and mask both set raise service event
// - scrub expiry sets bit 6
// - scrub expired flag protects configuration switch
// - trigger sets bit 7
// - trigger copies trigger mode into transmit mode
// - trigger flag protects current transmit state
// - mask register read/write, bits 6 and 7
// - timer counts 40.96 us units, 8-bit threshold
// - scrub starts only when enabled and triggered
// - threshold writes do not disturb running scrub
// - snapshot register reads timer upper eight bits
// - snapshot writes ignored, raise write reject
// - history writes refused where compare copy differs
// - history read refreshes compare copy
// - scrub sends two invalid, then scrub pairs
// - enabled trigger with no scrub pending or running loads transition config, scrubs changes
`timescale 1ns/1ps
module cmt_condition_scrub_timer #(
   parameter int TICK_CYCLES = cmt_pkg::SCRUB_TICK_CYCLES,
   parameter int CFG_W = 8
) (
   // clock and reset
   input wire logic SYS_CLK,
   input wire logic RST,
   // control bus access
   input wire logic CB_SEL,
   input wire logic CB_WE,
   input wire logic [7:0] CB_ADDR,
   input wire logic [7:0] CB_WDATA,
   output logic [7:0] CB_RDATA,
   output logic CB_ACK,
   // trigger and configuration inputs
   input wire logic TRIGGER,
   input wire logic [2:0] TRIGGER_TRANSMIT_MODE_FIELD,
   input wire logic SCRUB_ON_TRIGGER_ENABLE,
   input wire logic [CFG_W-1:0] TRIGGER_TRANSITION_CONFIGURATION,
   input wire logic [CFG_W-1:0] CONFIGURATION_SWITCH_NOW,
   // transmit state register load and guard
   output logic TRANSMIT_MODE_LOAD,
   output logic [2:0] TRANSMIT_MODE_FIELD,
   output logic TRANSMIT_STATE_PROTECT,
   // configuration switch load and guard
   output logic CONFIG_SWITCH_LOAD,
   output logic [CFG_W-1:0] CONFIG_SWITCH_VALUE,
   output logic CONFIG_SWITCH_PROTECT,
   // scrub activity
   output logic SCRUB_ACTIVE,
   output logic SCRUB_SEND_INVALID,
   output logic [CFG_W-1:0] SCRUB_PORTS,
   // condition flags of neighbouring registers
   output logic CONNECTION_SERVICE_EVENT_FLAG,
   output logic WRITE_COMMAND_REJECT_FLAG,
   output logic CONDITIONAL_WRITE_INHIBIT_FLAG
);

   scrub_if sif ();

   typedef struct packed {
      logic [7:0] history;
      logic [7:0] mask;
      logic [7:0] compare;
      logic [7:0] threshold;
      logic [7:0] rdata;
      logic ack;
      logic cse;
      logic wcr;
      logic conditional_write_inhibit_flag;
      logic tm_load;
      logic [2:0] tm_field;
      logic cfg_load;
      logic [CFG_W-1:0] cfg_value;
      logic [CFG_W-1:0] ports;
      logic start;
   } ctl_s;

   ctl_s r;
   ctl_s next_r;

   // ===========================================================
   // helpers
   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      hit = CB_SEL && (a == ofs);
   endfunction

   function automatic logic [7:0] impl(input logic [7:0] v);
      impl = v & cmt_pkg::IMPL_BITS;
   endfunction

   // ===========================================================
   // scrub timer
   scrub_timer #(
      .TICK_CYCLES(TICK_CYCLES)
   ) u_timer (
      .clk(SYS_CLK),
      .rst(RST),
      .sif(sif)
   );

   assign sif.start = r.start;
   assign sif.threshold = r.threshold;

   // ===========================================================
   // next state
   always_comb begin
      logic rd;
      logic wr;
      logic [7:0] hw_set;
      logic [7:0] keep;
      logic [7:0] differ;
      logic begin_scrub;
      rd = 1'b0;
      wr = 1'b0;
      hw_set = 8'h00;
      keep = 8'h00;
      differ = 8'h00;
      begin_scrub = 1'b0;
      next_r = r;
      rd = CB_SEL && !CB_WE;
      wr = CB_SEL && CB_WE;
      next_r.ack = 1'b0;
      next_r.wcr = 1'b0;
      next_r.conditional_write_inhibit_flag = 1'b0;
      next_r.tm_load = 1'b0;
      next_r.cfg_load = 1'b0;
      next_r.start = 1'b0;

      // hardware events
      if (TRIGGER) begin
         hw_set[cmt_pkg::TRIG_BIT] = 1'b1;
         next_r.tm_load = 1'b1;
         next_r.tm_field = TRIGGER_TRANSMIT_MODE_FIELD;
      end
      if (sif.expired) begin
         hw_set[cmt_pkg::SCRUB_BIT] = 1'b1;
      end

      // a trigger during a running scrub does not restart it
      begin_scrub = TRIGGER && SCRUB_ON_TRIGGER_ENABLE
                    && !sif.active && !r.start;
      if (begin_scrub) begin
         next_r.start = 1'b1;
         next_r.cfg_load = 1'b1;
         next_r.cfg_value = TRIGGER_TRANSITION_CONFIGURATION;
         next_r.ports = CONFIGURATION_SWITCH_NOW
                        ^ TRIGGER_TRANSITION_CONFIGURATION;
      end

      // register reads
      if (rd) begin
         if (hit(CB_ADDR, cmt_pkg::OFS_HISTORY)) begin
            next_r.rdata = impl(r.history);
            next_r.compare = impl(r.history);
            next_r.ack = 1'b1;
         end else if (hit(CB_ADDR, cmt_pkg::OFS_MASK)) begin
            next_r.rdata = impl(r.mask);
            next_r.ack = 1'b1;
         end else if (hit(CB_ADDR, cmt_pkg::OFS_RSVD_LO)
                      || hit(CB_ADDR, cmt_pkg::OFS_RSVD_HI)) begin
            next_r.rdata = 8'h00;
            next_r.ack = 1'b1;
         end else if (hit(CB_ADDR, cmt_pkg::OFS_THRESHOLD)) begin
            next_r.rdata = r.threshold;
            next_r.ack = 1'b1;
         end else if (hit(CB_ADDR, cmt_pkg::OFS_SNAPSHOT)) begin
            next_r.rdata = sif.snapshot;
            next_r.ack = 1'b1;
         end
      end

      // register writes
      if (wr) begin
         if (hit(CB_ADDR, cmt_pkg::OFS_HISTORY)) begin
            // only bits software has already seen may change
            differ = impl(r.history ^ r.compare);
            keep = differ | ~cmt_pkg::IMPL_BITS;
            next_r.history = (r.history & keep)
                             | (CB_WDATA & ~keep);
            next_r.conditional_write_inhibit_flag = |differ;
            next_r.ack = 1'b1;
         end else if (hit(CB_ADDR, cmt_pkg::OFS_MASK)) begin
            next_r.mask = impl(CB_WDATA);
            next_r.ack = 1'b1;
         end else if (hit(CB_ADDR, cmt_pkg::OFS_RSVD_LO)
                      || hit(CB_ADDR, cmt_pkg::OFS_RSVD_HI)) begin
            // left alone by software; a stray write changes nothing
            next_r.ack = 1'b1;
         end else if (hit(CB_ADDR, cmt_pkg::OFS_THRESHOLD)) begin
            next_r.threshold = CB_WDATA;
            next_r.ack = 1'b1;
         end else if (hit(CB_ADDR, cmt_pkg::OFS_SNAPSHOT)) begin
            next_r.wcr = 1'b1;
            next_r.ack = 1'b1;
         end
      end

      // hardware set wins over a clear in the same cycle
      next_r.history = impl(next_r.history | hw_set);
      next_r.cse = |(next_r.history & r.mask);
   end

   // ===========================================================
   // state register
   always_ff @(posedge SYS_CLK or posedge RST) begin
      if (RST) begin
         r <= '0;
         r.history <= cmt_pkg::HISTORY_RESET;
         r.mask <= cmt_pkg::MASK_RESET;
         r.threshold <= cmt_pkg::THRESHOLD_RESET;
      end else begin
         r <= next_r;
      end
   end

   // ===========================================================
   // outputs
   assign CB_RDATA = r.rdata;
   assign CB_ACK = r.ack;
   assign TRANSMIT_MODE_LOAD = r.tm_load;
   assign TRANSMIT_MODE_FIELD = r.tm_field;
   assign TRANSMIT_STATE_PROTECT = r.history[cmt_pkg::TRIG_BIT];
   assign CONFIG_SWITCH_LOAD = r.cfg_load;
   assign CONFIG_SWITCH_VALUE = r.cfg_value;
   assign CONFIG_SWITCH_PROTECT = r.history[cmt_pkg::SCRUB_BIT];
   assign SCRUB_ACTIVE = sif.active;
   assign SCRUB_SEND_INVALID = sif.send_invalid;
   assign SCRUB_PORTS = r.ports;
   assign CONNECTION_SERVICE_EVENT_FLAG = r.cse;
   assign WRITE_COMMAND_REJECT_FLAG = r.wcr;
   assign CONDITIONAL_WRITE_INHIBIT_FLAG = r.conditional_write_inhibit_flag;

endmodule

// ### dv/cmt_condition_scrub_timer_sva.sv
// port checker for the condition and scrub block
`timescale 1ns/1ps
module cmt_condition_scrub_timer_sva #(
   parameter int CFG_W = 8
) (
   // clock and reset
   input wire logic SYS_CLK,
   input wire logic RST,
   // inputs
   input wire logic CB_SEL,
   input wire logic CB_WE,
   input wire logic [7:0] CB_ADDR,
   input wire logic TRIGGER,
   input wire logic [2:0] TRIGGER_TRANSMIT_MODE_FIELD,
   input wire logic SCRUB_ON_TRIGGER_ENABLE,
   input wire logic [CFG_W-1:0] TRIGGER_TRANSITION_CONFIGURATION,
   // outputs
   input wire logic CB_ACK,
   input wire logic TRANSMIT_MODE_LOAD,
   input wire logic [2:0] TRANSMIT_MODE_FIELD,
   input wire logic TRANSMIT_STATE_PROTECT,
   input wire logic CONFIG_SWITCH_LOAD,
   input wire logic [CFG_W-1:0] CONFIG_SWITCH_VALUE,
   input wire logic CONFIG_SWITCH_PROTECT,
   input wire logic SCRUB_ACTIVE,
   input wire logic SCRUB_SEND_INVALID,
   input wire logic CONNECTION_SERVICE_EVENT_FLAG,
   input wire logic WRITE_COMMAND_REJECT_FLAG
);
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (RST);
   // ===========================================================
   // properties
   property p_ack;
      CB_SEL && CB_ADDR inside {[8'h20:8'h25]} |=> CB_ACK;
   endproperty
   a_ack: assert property (p_ack) else $error("no ack");
   property p_reject;
      CB_SEL && CB_WE && CB_ADDR == 8'h25 |=> WRITE_COMMAND_REJECT_FLAG;
   endproperty
   a_reject: assert property (p_reject) else $error("no reject");
   property p_mode;
      TRIGGER |=> TRANSMIT_MODE_LOAD && TRANSMIT_STATE_PROTECT &&
         TRANSMIT_MODE_FIELD == $past(TRIGGER_TRANSMIT_MODE_FIELD);
   endproperty
   a_mode: assert property (p_mode) else $error("bad mode");
   property p_cfg;
      TRIGGER && SCRUB_ON_TRIGGER_ENABLE && !SCRUB_ACTIVE &&
         !CONFIG_SWITCH_LOAD |=>
         CONFIG_SWITCH_LOAD &&
         CONFIG_SWITCH_VALUE == $past(TRIGGER_TRANSITION_CONFIGURATION);
   endproperty
   a_cfg: assert property (p_cfg) else $error("bad config");
   property p_start;
      $rose(SCRUB_ACTIVE) |->
         $past(TRIGGER, 2) && $past(SCRUB_ON_TRIGGER_ENABLE, 2);
   endproperty
   a_start: assert property (p_start) else $error("bad start");
   property p_invalid;
      $rose(SCRUB_ACTIVE) |-> SCRUB_SEND_INVALID[*4] ##1 !SCRUB_SEND_INVALID;
   endproperty
   a_invalid: assert property (p_invalid) else $error("bad lead");
   property p_expire;
      $fell(SCRUB_ACTIVE) |-> ##[0:1] CONFIG_SWITCH_PROTECT;
   endproperty
   a_expire: assert property (p_expire) else $error("no expiry");
   property p_event;
      CONNECTION_SERVICE_EVENT_FLAG |->
         TRANSMIT_STATE_PROTECT || CONFIG_SWITCH_PROTECT;
   endproperty
   a_event: assert property (p_event) else $error("stray event");
   c_scrub: cover property ($fell(SCRUB_ACTIVE));
   c_reject: cover property (WRITE_COMMAND_REJECT_FLAG);
   c_event: cover property (CONNECTION_SERVICE_EVENT_FLAG);
endmodule
bind cmt_condition_scrub_timer cmt_condition_scrub_timer_sva #(
   .CFG_W(CFG_W)
) i_cmt_condition_scrub_timer_sva (
   .SYS_CLK(SYS_CLK), .RST(RST), .CB_SEL(CB_SEL), .CB_WE(CB_WE),
   .CB_ADDR(CB_ADDR), .TRIGGER(TRIGGER),
   .TRIGGER_TRANSMIT_MODE_FIELD(TRIGGER_TRANSMIT_MODE_FIELD),
   .SCRUB_ON_TRIGGER_ENABLE(SCRUB_ON_TRIGGER_ENABLE),
   .TRIGGER_TRANSITION_CONFIGURATION(TRIGGER_TRANSITION_CONFIGURATION),
   .CB_ACK(CB_ACK), .TRANSMIT_MODE_LOAD(TRANSMIT_MODE_LOAD),
   .TRANSMIT_MODE_FIELD(TRANSMIT_MODE_FIELD),
   .TRANSMIT_STATE_PROTECT(TRANSMIT_STATE_PROTECT),
   .CONFIG_SWITCH_LOAD(CONFIG_SWITCH_LOAD),
   .CONFIG_SWITCH_VALUE(CONFIG_SWITCH_VALUE),
   .CONFIG_SWITCH_PROTECT(CONFIG_SWITCH_PROTECT),
   .SCRUB_ACTIVE(SCRUB_ACTIVE), .SCRUB_SEND_INVALID(SCRUB_SEND_INVALID),
   .CONNECTION_SERVICE_EVENT_FLAG(CONNECTION_SERVICE_EVENT_FLAG),
   .WRITE_COMMAND_REJECT_FLAG(WRITE_COMMAND_REJECT_FLAG)
);

// ### dv/cmt_host_model.sv
// control bus host issuing single-cycle register accesses
`timescale 1ns/1ps
module cmt_host_model (
   // clock
   input wire logic clk,
   // bus request
   output logic sel,
   output logic we,
   output logic [7:0] addr,
   output logic [7:0] wdata
);
   initial begin
      sel = 1'b0;
      we = 1'b0;
      addr = 8'h00;
      wdata = 8'h00;
   end
   // released address and data lines show the inverse so stale values never pass
   task automatic access(input logic w, input logic [7:0] a,
      input logic [7:0] d);
      if (w && a inside {8'h22, 8'h23}) return;
      @(posedge clk);
      sel <= 1'b1;
      we <= w;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      sel <= 1'b0;
      addr <= ~a;
      wdata <= ~d;
      @(posedge clk);
   endtask
endmodule

// ### dv/cmt_condition_scrub_timer_tb_top.sv
// self-checking bench for the condition and scrub block
`timescale 1ns/1ps
module cmt_condition_scrub_timer_tb_top;
   localparam int TICK = 8;
   logic SYS_CLK = 1'b0;
   logic RST = 1'b1;
   logic CB_SEL, CB_WE, CB_ACK, TRIGGER = 1'b0;
   logic [7:0] CB_ADDR, CB_WDATA, CB_RDATA, n1, n2, rnd = 8'h1B;
   logic SCRUB_ON_TRIGGER_ENABLE = 1'b0;
   logic [2:0] TRIGGER_TRANSMIT_MODE_FIELD = 3'h0, TRANSMIT_MODE_FIELD;
   logic [7:0] TRIGGER_TRANSITION_CONFIGURATION = 8'h00;
   logic [7:0] CONFIGURATION_SWITCH_NOW = 8'h00;
   logic [7:0] CONFIG_SWITCH_VALUE, SCRUB_PORTS;
   logic TRANSMIT_MODE_LOAD, TRANSMIT_STATE_PROTECT, CONFIG_SWITCH_LOAD;
   logic CONFIG_SWITCH_PROTECT, SCRUB_ACTIVE, SCRUB_SEND_INVALID;
   logic CONNECTION_SERVICE_EVENT_FLAG, WRITE_COMMAND_REJECT_FLAG;
   logic CONDITIONAL_WRITE_INHIBIT_FLAG;
   logic [1:0] pulses;
   logic [10:0] exp_q[$], got_e;
   int error_cnt = 0;
   int num_checks = 0;
   always #2 SYS_CLK = ~SYS_CLK;
   cmt_condition_scrub_timer #(.TICK_CYCLES(TICK), .CFG_W(8))
      i_cmt_condition_scrub_timer (
      .SYS_CLK(SYS_CLK), .RST(RST), .CB_SEL(CB_SEL), .CB_WE(CB_WE),
      .CB_ADDR(CB_ADDR), .CB_WDATA(CB_WDATA), .CB_RDATA(CB_RDATA),
      .CB_ACK(CB_ACK), .TRIGGER(TRIGGER),
      .TRIGGER_TRANSMIT_MODE_FIELD(TRIGGER_TRANSMIT_MODE_FIELD),
      .SCRUB_ON_TRIGGER_ENABLE(SCRUB_ON_TRIGGER_ENABLE),
      .TRIGGER_TRANSITION_CONFIGURATION(TRIGGER_TRANSITION_CONFIGURATION),
      .CONFIGURATION_SWITCH_NOW(CONFIGURATION_SWITCH_NOW),
      .TRANSMIT_MODE_LOAD(TRANSMIT_MODE_LOAD),
      .TRANSMIT_MODE_FIELD(TRANSMIT_MODE_FIELD),
      .TRANSMIT_STATE_PROTECT(TRANSMIT_STATE_PROTECT),
      .CONFIG_SWITCH_LOAD(CONFIG_SWITCH_LOAD),
      .CONFIG_SWITCH_VALUE(CONFIG_SWITCH_VALUE),
      .CONFIG_SWITCH_PROTECT(CONFIG_SWITCH_PROTECT),
      .SCRUB_ACTIVE(SCRUB_ACTIVE), .SCRUB_SEND_INVALID(SCRUB_SEND_INVALID),
      .SCRUB_PORTS(SCRUB_PORTS),
      .CONNECTION_SERVICE_EVENT_FLAG(CONNECTION_SERVICE_EVENT_FLAG),
      .WRITE_COMMAND_REJECT_FLAG(WRITE_COMMAND_REJECT_FLAG),
      .CONDITIONAL_WRITE_INHIBIT_FLAG(CONDITIONAL_WRITE_INHIBIT_FLAG)
   );
   assign pulses = {WRITE_COMMAND_REJECT_FLAG,
      CONDITIONAL_WRITE_INHIBIT_FLAG};
   cmt_host_model i_cmt_host_model (.clk(SYS_CLK), .sel(CB_SEL),
      .we(CB_WE), .addr(CB_ADDR), .wdata(CB_WDATA));
   // ===========================================================
   // helpers
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   task automatic chk(input logic [15:0] s, input logic [15:0] e);
      num_checks++;
      if (s !== e) begin
         error_cnt++;
         $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task automatic print_verdict();
      $display("checks=%0d errors=%0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // bit 8 of a note asks for a read data comparison, bits 10:9 give
   // the reject and inhibit pulses expected beside the acknowledge
   task automatic rd(input logic [7:0] a, input logic [8:0] e);
      exp_q.push_back({2'b00, e});
      i_cmt_host_model.access(1'b0, a, 8'h00);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d,
      input logic c);
      exp_q.push_back({a == cmt_pkg::OFS_SNAPSHOT, c, 9'h000});
      i_cmt_host_model.access(1'b1, a, d);
   endtask
   task automatic fire(input logic [2:0] m, input logic [7:0] t);
      @(posedge SYS_CLK);
      TRIGGER <= 1'b1;
      TRIGGER_TRANSMIT_MODE_FIELD <= m;
      TRIGGER_TRANSITION_CONFIGURATION <= t;
      CONFIGURATION_SWITCH_NOW <= {t[3:0], t[7:4]};
      @(posedge SYS_CLK);
      TRIGGER <= 1'b0;
   endtask
   // threshold nw is written mid-scrub and must not shorten this one
   task automatic scrub(input logic [7:0] n, input logic [7:0] nw);
      int cnt;
      logic [7:0] t;
      rnd = lfsr(rnd);
      t = rnd;
      fire(t[2:0], t);
      fork
         begin
            repeat (3) @(posedge SYS_CLK);
            wr(8'h24, nw, 1'b0);
            // taken before the first tick, so the full threshold shows
            rd(8'h25, {1'b1, n});
         end
         begin
            cnt = 0;
            while (SCRUB_ACTIVE !== 1'b1 && cnt < 8) begin
               @(negedge SYS_CLK);
               cnt++;
            end
            cnt = 0;
            while (SCRUB_ACTIVE === 1'b1 && cnt < 4000) begin
               @(negedge SYS_CLK);
               cnt++;
            end
         end
      join
      chk(16'(cnt), 16'((n == 8'h00 ? 1 : n) * TICK));
      chk(16'(TRANSMIT_MODE_FIELD), 16'(t[2:0]));
      chk(16'(CONFIG_SWITCH_VALUE), 16'(t));
      chk(16'(SCRUB_PORTS), 16'(t ^ CONFIGURATION_SWITCH_NOW));
   endtask
   // ===========================================================
   // read data monitor
   always @(negedge SYS_CLK) begin
      if (CB_ACK === 1'b1 && exp_q.size() > 0) begin
         got_e = exp_q.pop_front();
         if (got_e[8]) chk(16'(CB_RDATA), 16'(got_e[7:0]));
         chk(16'(pulses), 16'(got_e[10:9]));
      end
   end
   initial begin
      repeat (20000) @(posedge SYS_CLK);
      error_cnt++;
      print_verdict();
   end
   // ===========================================================
   // main sequence
   initial begin
      repeat (8) @(posedge SYS_CLK);
      RST <= 1'b0;
      rd(8'h20, 9'h100);
      rd(8'h21, 9'h100);
      rd(8'h24, 9'h100);
      wr(8'h21, 8'hFF, 1'b0);
      rd(8'h21, 9'h1C0);
      rd(8'h22, 9'h100);
      wr(8'h25, 8'h5A, 1'b0);
      SCRUB_ON_TRIGGER_ENABLE <= 1'b1;
      n1 = {6'h00, rnd[1:0]};
      n2 = {6'h00, rnd[3:2]} + 8'h01;
      wr(8'h24, n1, 1'b0);
      scrub(n1, n2);
      chk(16'(CONNECTION_SERVICE_EVENT_FLAG), 16'h0001);
      rd(8'h25, 9'h100);
      // history changed since the last read, so this write is refused
      wr(8'h20, 8'h00, 1'b1);
      rd(8'h20, 9'h1C0);
      wr(8'h20, 8'h00, 1'b0);
      rd(8'h20, 9'h100);
      @(negedge SYS_CLK);
      chk(16'(CONNECTION_SERVICE_EVENT_FLAG), 16'h0000);
      scrub(n2, 8'h00);
      @(posedge SYS_CLK);
      SCRUB_ON_TRIGGER_ENABLE <= 1'b0;
      fire(3'h1, 8'h5A);
      repeat (4) @(negedge SYS_CLK);
      chk(16'(SCRUB_ACTIVE), 16'h0000);
      chk(16'(exp_q.size()), 16'h0000);
      print_verdict();
   end
endmodule
